//--- src/adc_ctrl.sv
// Function
// RULE1 - wait at least 200 us after reset before any memory cycle
// RULE2 - after the pause run eight row strobe cycles before accesses
// RULE3 - after more than 16 ms idle rerun eight row strobe wake cycles
// RULE4 - drive row field at row strobe fall, column field at column fall
// RULE5 - device decodes twenty address bits into one word location
// RULE6 - row strobe falls first, column strobe after the strobe delay
// RULE7 - device ignores column strobe until its row strobe is established
// RULE8 - write select high before column strobe falls for a read
// RULE9 - read data valid after last of row, column and gate access
// RULE10 - device drives data only while column strobe and gate are low
// RULE11 - write select stays high through read until a strobe rises
// RULE12 - keep row strobe high for precharge before next active cycle
// RULE13 - write is signalled by driving write select low
// RULE14 - write select low before column fall gives early write, outputs off
// RULE15 - write data sampled at column strobe fall in early write, held
// RULE16 - after write select falls keep both strobes low at least 20 ns
// RULE17 - late write needs gate high; not used, gate high in writes
// RULE18 - late write select gives old data out first; not used here
// RULE19 - write select timing meeting neither case gives undefined data
// RULE20 - late write select may trail up to about 10 us; not used
// RULE21 - column before row refresh uses the internal row counter
// RULE22 - refresh all 1024 rows each 16 ms
// RULE23 - row-only strobe cycle refreshes the addressed row
// RULE24 - write select high around row strobe fall in refresh
`timescale 1ns/1ps
`include "adc_cfg.svh"
module adc_ctrl
	import adc_pkg::*;
(
	input  wire logic        clk_i,        // 10 MHz clock
	input  wire logic        rst_n_i,      // async reset, active low
	input  wire logic        req_valid_i,  // access request
	input  wire logic        req_write_i,  // 1 write, 0 read
	input  wire logic [19:0] req_addr_i,   // row in high ten bits
	input  wire logic [39:0] req_wdata_i,  // write data
	output logic             req_ready_o,  // pulses the cycle after a request is taken
	output logic [39:0]      rd_data_o,    // read data from fifo
	output logic             rd_valid_o,   // read data valid
	input  wire logic        rd_ready_i,   // read data consumer ready
	output logic             init_done_o,  // initialisation complete
	output logic [9:0]       muxed_address_o, // multiplexed address
	output logic             ras_n_o,      // row strobe, active low
	output logic             cas_n_o,      // column strobe, active low
	output logic             we_n_o,       // write select, active low
	output logic             oe_n_o,       // output gate, active low
	output logic [39:0]      data_bus_o,   // data out
	output logic             data_bus_oe_o, // data bus drive enable
	input  wire logic [39:0] data_bus_i    // data in from pins
);
	localparam int PW = `ADC_PWRUP_CYC;
	localparam int IW = `ADC_IDLE_CYC;
	localparam int RW = `ADC_REFRESH_CYC;
	localparam int RASC = (`ADC_RAS_CYC > `ADC_RAC_CYC) ? `ADC_RAS_CYC : `ADC_RAC_CYC;

	adc_state_t  state_reg;
	adc_state_t  state_next;
	logic [17:0] tmr_reg;
	logic [17:0] idle_reg;
	logic [7:0]  ref_reg;
	logic [3:0]  cnt_reg;
	logic [3:0]  wait_reg;
	logic        wr_reg;
	logic [19:0] addr_reg;
	logic [39:0] wdata_reg;
	logic        ref_pend_reg;
	logic [39:0] dq_s1_reg;
	logic [39:0] dq_s2_reg;
	logic [39:0] dq_s3_reg;
	logic        cap_reg;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [39:0] fifo_out_data;
	logic        rdv_reg;
	logic [39:0] rdd_reg;

	// pauses and periodic refresh
	wire pwrup_done = tmr_reg == 18'(PW);
	wire idle_long  = idle_reg == 18'(IW);
	wire ref_tick   = ref_reg == 8'(RW - 1);
	wire wait_done  = wait_reg == 4'h0;
	// reads only start while the fifo has room, which stalls the requester
	wire take       = (state_reg == ST_IDLE) & req_valid_i & ~ref_pend_reg & ~idle_long
	                & (req_write_i | fifo_in_ready);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_PWRUP:    if (pwrup_done) state_next = ST_INIT_RAS; // RULE1
			ST_INIT_RAS: if (wait_done) state_next = ST_INIT_PRE;
			ST_INIT_PRE: if (wait_done) state_next = (cnt_reg == 4'h1) ? ST_IDLE : ST_INIT_RAS;
			ST_IDLE: begin
				if (idle_long) state_next = ST_INIT_RAS; // RULE3
				else if (ref_pend_reg) state_next = ST_REF_CAS;
				else if (take) state_next = ST_ROW;
			end
			ST_ROW:      if (wait_done) state_next = ST_COL; // RULE6
			ST_COL:      state_next = ST_WAIT;
			ST_WAIT:     if (wait_done) state_next = ST_END;
			ST_END:      state_next = ST_PRE;
			ST_REF_CAS:  state_next = ST_REF_RAS;
			ST_REF_RAS:  if (wait_done) state_next = ST_PRE;
			ST_PRE:      if (wait_done) state_next = ST_IDLE; // RULE12
			default:     state_next = ST_PWRUP;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_PWRUP;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tmr_reg <= '0;
		end else if (state_reg == ST_PWRUP && !pwrup_done) begin
			tmr_reg <= tmr_reg + 18'h1;
		end
	end

	// idle time since last row strobe activity
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_reg <= '0;
		end else if (!ras_n_o || state_reg == ST_PWRUP) begin
			idle_reg <= '0;
		end else if (!idle_long) begin
			idle_reg <= idle_reg + 18'h1;
		end
	end

	// one column-before-row refresh every 15.6 us covers 1024 rows in 16 ms
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_reg      <= '0;
			ref_pend_reg <= 1'b0;
		end else begin
			ref_reg <= (ref_tick || !init_done_o) ? 8'h0 : ref_reg + 8'h1;
			if (ref_tick) ref_pend_reg <= 1'b1; // RULE22
			else if (state_reg == ST_REF_CAS) ref_pend_reg <= 1'b0;
		end
	end

	// wake and init cycle counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 4'h0;
		end else if (state_next == ST_INIT_RAS && state_reg != ST_INIT_RAS
		             && state_reg != ST_INIT_PRE) begin
			cnt_reg <= 4'(`ADC_INIT_CYCLES); // RULE2
		end else if (state_reg == ST_INIT_PRE && wait_done) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end

	// phase delay counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_reg <= 4'h0;
		end else if (state_next != state_reg) begin
			unique case (state_next)
				ST_INIT_RAS, ST_REF_RAS: wait_reg <= 4'(`ADC_RAS_CYC - 1);
				ST_WAIT:  wait_reg <= 4'(RASC - 1); // RULE9
				ST_PRE, ST_INIT_PRE: wait_reg <= 4'(`ADC_RP_CYC - 1);
				default:  wait_reg <= 4'h0;
			endcase
		end else if (!wait_done) begin
			wait_reg <= wait_reg - 4'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_reg    <= 1'b0;
			addr_reg  <= '0;
			wdata_reg <= '0;
		end else if (take) begin
			wr_reg    <= req_write_i;
			addr_reg  <= req_addr_i;
			wdata_reg <= req_wdata_i;
		end
	end

	// pin drive
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ras_n_o         <= 1'b1;
			cas_n_o         <= 1'b1;
			we_n_o          <= 1'b1;
			oe_n_o          <= 1'b1;
			muxed_address_o <= '0;
			data_bus_o      <= '0;
			data_bus_oe_o   <= 1'b0;
		end else begin
			unique case (state_next)
				ST_INIT_RAS: begin
					ras_n_o <= 1'b0; // RULE23
					muxed_address_o <= 10'(cnt_reg);
				end
				ST_ROW: begin
					ras_n_o <= 1'b0;
					muxed_address_o <= take ? req_addr_i[19:10] : addr_reg[19:10]; // RULE4
					we_n_o <= take ? ~req_write_i : ~wr_reg; // RULE8 RULE13 RULE14 RULE20
					data_bus_o <= take ? req_wdata_i : wdata_reg;
					data_bus_oe_o <= take ? req_write_i : wr_reg; // RULE15
				end
				ST_COL: begin
					cas_n_o <= 1'b0; // RULE6
					muxed_address_o <= addr_reg[9:0]; // RULE4
					oe_n_o <= wr_reg; // RULE17
				end
				ST_REF_CAS: begin
					cas_n_o <= 1'b0; // RULE21
					we_n_o  <= 1'b1; // RULE24
				end
				ST_REF_RAS: ras_n_o <= 1'b0; // RULE24
				ST_WAIT: ; // RULE16
				ST_END: begin
					ras_n_o <= 1'b1;
					cas_n_o <= 1'b1;
					oe_n_o  <= 1'b1; // RULE10
				end
				default: begin
					ras_n_o <= 1'b1;
					cas_n_o <= 1'b1;
					we_n_o  <= 1'b1; // RULE11
					data_bus_oe_o <= 1'b0;
				end
			endcase
		end
	end

	// data pin synchroniser; the edge that opens the last wait cycle samples read data
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
			dq_s3_reg <= '0;
			cap_reg   <= 1'b0;
		end else begin
			dq_s1_reg <= data_bus_i;
			dq_s2_reg <= dq_s1_reg;
			dq_s3_reg <= dq_s2_reg;
			cap_reg   <= (state_reg == ST_END) & ~wr_reg; // RULE9
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_ready_o <= 1'b0;
			init_done_o <= 1'b0;
		end else begin
			req_ready_o <= take;
			if (state_reg == ST_INIT_PRE && state_next == ST_IDLE) init_done_o <= 1'b1;
		end
	end

	adc_fifo #(
		.WIDTH(`ADC_DW),
		.DEPTH(`ADC_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   (dq_s3_reg),
		.in_valid_i  (cap_reg),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (fifo_out_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (~rdv_reg | rd_ready_i)
	);

	// output stage register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdv_reg <= 1'b0;
			rdd_reg <= '0;
		end else if (!rdv_reg || rd_ready_i) begin
			rdv_reg <= fifo_out_valid;
			rdd_reg <= fifo_out_data;
		end
	end
	assign rd_valid_o = rdv_reg;
	assign rd_data_o  = rdd_reg;
endmodule : adc_ctrl

//--- src/adc_cfg.svh
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

`define ADC_CLK_HZ        10000000
`define ADC_PWRUP_US      200
`define ADC_PWRUP_CYC     ((`ADC_PWRUP_US * (`ADC_CLK_HZ / 1000000)))
`define ADC_IDLE_MS       16
`define ADC_IDLE_CYC      ((`ADC_IDLE_MS * (`ADC_CLK_HZ / 1000)))
`define ADC_REFRESH_NS    15600
`define ADC_REFRESH_CYC   ((`ADC_REFRESH_NS * (`ADC_CLK_HZ / 1000000)) / 1000)
`define ADC_INIT_CYCLES   8
`define ADC_ROWS          1024
`define ADC_RP_NS         50
`define ADC_RP_CYC        (((`ADC_RP_NS * (`ADC_CLK_HZ / 1000000)) + 999) / 1000)
`define ADC_RAS_NS        70
`define ADC_RAS_CYC       (((`ADC_RAS_NS * (`ADC_CLK_HZ / 1000000)) + 999) / 1000)
`define ADC_CAS_NS        20
`define ADC_CAS_CYC       (((`ADC_CAS_NS * (`ADC_CLK_HZ / 1000000)) + 999) / 1000)
`define ADC_RAC_NS        70
`define ADC_RAC_CYC       (((`ADC_RAC_NS * (`ADC_CLK_HZ / 1000000)) + 999) / 1000)
`define ADC_AW            10
`define ADC_DW            40
`define ADC_FIFO_DEPTH    16

`endif

//--- src/adc_pkg.sv
package adc_pkg;
	typedef enum logic [3:0] {
		ST_PWRUP,
		ST_INIT_RAS,
		ST_INIT_PRE,
		ST_IDLE,
		ST_ROW,
		ST_COL,
		ST_WAIT,
		ST_END,
		ST_REF_CAS,
		ST_REF_RAS,
		ST_PRE
	} adc_state_t;
endpackage : adc_pkg

//--- src/adc_fifo.sv
`timescale 1ns/1ps
module adc_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,    // clock
	input  wire logic             rst_n_i,  // async reset
	input  wire logic [WIDTH-1:0] in_data_i,  // write data
	input  wire logic             in_valid_i, // write valid
	output logic                  in_ready_o, // not full
	output logic      [WIDTH-1:0] out_data_o, // head word
	output logic                  out_valid_o, // not empty
	input  wire logic             out_ready_i  // pop
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	wire              push = in_valid_i & in_ready_o;
	wire              pop  = out_valid_o & out_ready_i;
	assign in_ready_o  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
	assign out_valid_o = wr_reg != rd_reg;
	assign out_data_o  = mem[rd_reg[AW-1:0]];
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (push) wr_reg <= wr_reg + 1'b1;
			if (pop) rd_reg <= rd_reg + 1'b1;
		end
	end
endmodule : adc_fifo

//--- bench/adc_dram_model.sv
`timescale 1ns/1ps
module adc_dram_model #(
	parameter int ACC_NS = 20 // access delay
) (
	input  wire logic        ras_n_i,  // row strobe
	input  wire logic        cas_n_i,  // column strobe
	input  wire logic        we_n_i,   // write select
	input  wire logic        oe_n_i,   // output gate
	input  wire logic [9:0]  addr_i,   // muxed_address
	input  wire logic [39:0] d_i,      // controller data
	input  wire logic        d_oe_i,   // controller drives
	output logic      [39:0] dq_o,     // resolved data_bus
	output logic      [15:0] cbr_cnt_o // refresh count
);
	logic [39:0] mem [logic [19:0]];
	logic [9:0]  row_reg = 10'h0;
	logic [39:0] q_reg = 40'h0;
	logic        rd_reg = 1'b0;
	logic [9:0]  col_reg = 10'h0;
	realtime     cas_t = 0.0;
	logic        drv;
	initial cbr_cnt_o = 16'h0;
	// strobe and address leave the controller on one edge; look just after it
	always @(negedge ras_n_i) begin
		#1;
		if (cas_n_i)
			row_reg = addr_i;
		else
			cbr_cnt_o = cbr_cnt_o + 16'h1;
	end
	// a column edge counts only once the row strobe is low
	always @(negedge cas_n_i) begin
		#1;
		if (!ras_n_i) begin
			col_reg = addr_i;
			cas_t = $realtime;
			rd_reg = we_n_i;
			if (!we_n_i)
				mem[{row_reg, addr_i}] = d_i;
			q_reg = mem.exists({row_reg, addr_i}) ? mem[{row_reg, addr_i}] : 40'h0;
		end
	end
	// late write select: write now; old data stays out only when late enough
	always @(negedge we_n_i) begin
		if (!ras_n_i && !cas_n_i) begin
			mem[{row_reg, col_reg}] = d_i;
			if ($realtime - cas_t < 50.0)
				rd_reg = 1'b0;
		end
	end
	assign #(ACC_NS) drv = !cas_n_i && !oe_n_i && rd_reg;
	// released bus shows the inverse of the last word
	assign dq_o = d_oe_i ? d_i : (drv ? q_reg : ~q_reg);
endmodule : adc_dram_model

//--- bench/adc_ctrl_chk.sv
`timescale 1ns/1ps
module adc_ctrl_chk (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        init_done_o,
	input wire logic        ras_n_o,
	input wire logic        cas_n_o,
	input wire logic        we_n_o,
	input wire logic        oe_n_o,
	input wire logic [39:0] data_bus_o,
	input wire logic        data_bus_oe_o
);
	logic [11:0] up_cnt;
	logic [3:0]  ras_cnt;
	logic [8:0]  gap_cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_cnt  <= 12'h0;
			ras_cnt <= 4'h0;
			gap_cnt <= 9'h0;
		end else begin
			up_cnt  <= (up_cnt == 12'hfff) ? up_cnt : up_cnt + 12'h1;
			ras_cnt <= ($fell(ras_n_o) && ras_cnt != 4'hf) ? ras_cnt + 4'h1 : ras_cnt;
			gap_cnt <= $fell(ras_n_o) ? 9'h0 : ((gap_cnt == 9'h1ff) ? gap_cnt : gap_cnt + 9'h1);
		end
	end
	pause_hold_a: assert property (up_cnt < 12'h7cf |-> ras_n_o)
		else $error("row strobe active during power-up pause");
	init_count_a: assert property ($rose(init_done_o) |-> ras_cnt >= 4'h8)
		else $error("init done before eight row cycles");
	refresh_gap_a: assert property (init_done_o |-> gap_cnt < 9'h0c8)
		else $error("row strobe idle too long");
	ras_first_a: assert property ($fell(cas_n_o) && !ras_n_o |-> !$past(ras_n_o))
		else $error("column strobe fell with row strobe");
	read_sel_a: assert property ($fell(cas_n_o) |-> we_n_o == !data_bus_oe_o)
		else $error("write select wrong at column strobe");
	we_hold_a: assert property (!cas_n_o && !$past(cas_n_o) |-> $stable(we_n_o))
		else $error("write select moved under column strobe");
	precharge_a: assert property ($rose(ras_n_o) && !$past(cas_n_o) |=> ras_n_o)
		else $error("row precharge too short");
	gate_off_a: assert property (!we_n_o |-> oe_n_o)
		else $error("output gate low in write");
	cbr_we_a: assert property ($fell(ras_n_o) && !cas_n_o |-> we_n_o && $past(we_n_o))
		else $error("write select low at refresh row edge");
	wdata_hold_a: assert property (data_bus_oe_o && !cas_n_o |-> $stable(data_bus_o))
		else $error("write data moved under column strobe");
	wr_strobe_a: assert property ($fell(we_n_o) |-> !ras_n_o ##1 (!ras_n_o && !cas_n_o))
		else $error("strobes not low after write select");
	cover property ($fell(cas_n_o) && we_n_o && !ras_n_o);
	cover property ($fell(cas_n_o) && !we_n_o);
	cover property ($fell(ras_n_o) && !cas_n_o);
endmodule : adc_ctrl_chk
bind adc_ctrl adc_ctrl_chk adc_ctrl_chk_inst (.clk_i, .rst_n_i, .init_done_o, .ras_n_o,
	.cas_n_o, .we_n_o, .oe_n_o, .data_bus_o, .data_bus_oe_o);

//--- bench/tb_async_dram_cycle_protocol.sv
`timescale 1ns/1ps
module tb_async_dram_cycle_protocol;
	logic        clk_i, rst_n_i, req_valid_i, req_write_i, req_ready_o, rd_valid_o;
	logic        rd_ready_i, init_done_o, ras_n_o, cas_n_o, we_n_o, oe_n_o, data_bus_oe_o;
	logic [19:0] req_addr_i;
	logic [39:0] req_wdata_i, rd_data_o, data_bus_o, data_bus_i;
	logic [9:0]  muxed_address_o;
	logic [15:0] cbr_cnt, n0;
	logic [31:0] seed, rseed;
	logic        stall, ok;
	int          err_count, samples_checked, taken, i;
	logic [39:0] exp_q [$];
	logic [39:0] shadow [logic [19:0]];
	logic [19:0] addrs [$];

	adc_ctrl adc_ctrl_inst (.clk_i, .rst_n_i, .req_valid_i, .req_write_i, .req_addr_i,
		.req_wdata_i, .req_ready_o, .rd_data_o, .rd_valid_o, .rd_ready_i, .init_done_o,
		.muxed_address_o, .ras_n_o, .cas_n_o, .we_n_o, .oe_n_o, .data_bus_o,
		.data_bus_oe_o, .data_bus_i);
	adc_dram_model #(.ACC_NS(20)) adc_dram_model_inst (.ras_n_i(ras_n_o), .cas_n_i(cas_n_o),
		.we_n_i(we_n_o), .oe_n_i(oe_n_o), .addr_i(muxed_address_o), .d_i(data_bus_o),
		.d_oe_i(data_bus_oe_o), .dq_o(data_bus_i), .cbr_cnt_o(cbr_cnt));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic check_word(input logic [39:0] got, input logic [39:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t read got %h exp %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_flag(input logic good, input string what);
		samples_checked++;
		if (good !== 1'b1) begin
			err_count++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : check_flag

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// holds the request until the taken pulse, or gives up after lim cycles
	task automatic do_req(input logic wr, input logic [19:0] a, input logic [39:0] d,
		input int lim, output logic took);
		int n;
		@(negedge clk_i);
		req_valid_i = 1'b1;
		req_write_i = wr;
		req_addr_i = a;
		req_wdata_i = d;
		took = 1'b0;
		for (n = 0; n < lim && !took; n++) begin
			@(posedge clk_i);
			took = req_ready_o === 1'b1;
		end
		@(negedge clk_i);
		req_valid_i = 1'b0;
		@(posedge clk_i);
		took = took | (req_ready_o === 1'b1);
	endtask : do_req

	task automatic access(input logic wr, input logic [19:0] a);
		logic [39:0] d;
		logic        t;
		seed = lfsr_next(seed);
		d[39:32] = seed[7:0];
		seed = lfsr_next(seed);
		d[31:0] = seed;
		if (!wr)
			exp_q.push_back(shadow[a]);
		do_req(wr, a, d, 400, t);
		if (!t) begin
			check_flag(1'b0, "request never taken");
			tally_and_finish();
		end
		if (wr)
			shadow[a] = d;
	endtask : access

	always #50 clk_i = ~clk_i;

	always @(negedge clk_i) begin
		rseed <= lfsr_next(rseed);
		rd_ready_i <= stall ? 1'b0 : (rseed[0] | rseed[5]);
	end

	always @(posedge clk_i) begin
		if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
			if (exp_q.size() == 0)
				check_flag(1'b0, "unexpected read word");
			else
				check_word(rd_data_o, exp_q.pop_front());
		end
	end

	initial begin
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		req_valid_i = 1'b0;
		req_write_i = 1'b0;
		req_addr_i = 20'h0;
		req_wdata_i = 40'h0;
		rd_ready_i = 1'b0;
		stall = 1'b1;
		seed = 32'h00016d6f;
		rseed = 32'h00016d6f;
		err_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (1900) @(posedge clk_i);
		check_flag(init_done_o === 1'b0, "init done inside pause");
		for (i = 0; i < 3000 && init_done_o !== 1'b1; i++)
			@(posedge clk_i);
		check_flag(init_done_o === 1'b1, "init never done");
		if (init_done_o !== 1'b1)
			tally_and_finish();
		stall = 1'b0;
		addrs = {20'h00000, 20'hfffff, 20'h003ff, 20'h00400, 20'hffc00};
		repeat (12) begin
			seed = lfsr_next(seed);
			addrs.push_back(seed[19:0]);
		end
		foreach (addrs[k]) access(1'b1, addrs[k]);
		foreach (addrs[k]) access(1'b0, addrs[k]);
		access(1'b1, 20'h003ff);
		access(1'b0, 20'h003ff);
		n0 = cbr_cnt;
		repeat (400) @(posedge clk_i);
		check_flag(cbr_cnt - n0 >= 16'h2, "no refresh while idle");
		// stall the consumer until reads are refused, then drain
		stall = 1'b1;
		taken = 0;
		ok = 1'b1;
		while (ok && taken < 20) begin
			exp_q.push_back(shadow[20'hfffff]);
			do_req(1'b0, 20'hfffff, 40'h0, 60, ok);
			if (ok)
				taken++;
			else
				void'(exp_q.pop_back());
		end
		check_flag(taken >= 16 && taken <= 18, "read buffer depth");
		stall = 1'b0;
		for (i = 0; i < 3000 && exp_q.size() > 0; i++)
			@(posedge clk_i);
		check_flag(exp_q.size() == 0, "read buffer not drained");
		tally_and_finish();
	end
endmodule : tb_async_dram_cycle_protocol
